/* core/rtc_calendar.v */
// low power BCD calendar clock with alarm, wakeup timer, crystal watch and tamper inputs
`timescale 1ns/1ps
`include "rtc_calendar_map.vh"

// What this block does
// [RULE1] The calendar is held as BCD seconds, minutes, hours, weekday, date, month and year, hours in 12 or 24 hour form.
// [RULE2] The date wraps at 28, 29, 30 or 31 days as the month and leap year demand.
// [RULE3] The subsecond count is readable as a plain binary number.
// [RULE4] Software can hold back the calendar by 1 to 32767 clock pulses to line it up with a master clock.
// [RULE5] A programmed calibration drops or adds clock pulses so timekeeping reaches about 0.95 ppm (one pulse in 2^20).
// [RULE6] An alarm and a periodic wakeup each raise an event able to wake the system.
// [RULE7] At the finest wakeup resolution of two clock pulses the period spans 61 us to 8 s.
// [RULE8] Coarser wakeup resolutions stretch the period to thirty-six hours.
// [RULE9] Calendar alarms repeat from every second to every year by masking compared fields.
// [RULE10] A stalled crystal clock is detected and raises a waking event.
// [RULE11] On crystal failure the clock can move to the internal RC without software.
// [RULE12] Three tamper pins pass a programmable filter and raise a waking event.
// [RULE13] Each calendar field carries into the next one when it wraps.
module rtc_calendar #(
  parameter [19:0] FAIL_CYCLES = `FAIL_CYCLES
) (
  input  wire        clk_sys,
  input  wire        resetn,
  input  wire        xtalClkPin,
  input  wire        rcClkPin,
  input  wire [2:0]  tamperPin,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         irq
);

  // ****************
  // functions
  // ****************
  function [7:0] bcdInc;
    input [7:0] v;
    bcdInc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction

  function [5:0] lastDay;
    input [4:0] m;
    input [7:0] y;
    reg leap;
    begin
      leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                  : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
      case (m)
        5'h02:                      lastDay = leap ? 6'h29 : 6'h28;
        5'h04, 5'h06, 5'h09, 5'h11: lastDay = 6'h30;
        default:                    lastDay = 6'h31;
      endcase
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1)
        if (strb[k])
          merge[k*8 +: 8] = nw[k*8 +: 8];
    end
  endfunction

  // ****************
  // state
  // ****************
  reg  [1:0]  xtalSync;
  reg  [1:0]  rcSync;
  reg  [1:0]  tSync0;
  reg  [1:0]  tSync1;
  reg  [1:0]  tSync2;
  reg         xtalLast;
  reg         rcLast;
  reg  [6:0]  sec_reg;
  reg  [6:0]  min_reg;
  reg  [5:0]  hour_reg;
  reg         pm_reg;
  reg  [2:0]  wday_reg;
  reg  [5:0]  date_reg;
  reg  [4:0]  month_reg;
  reg  [7:0]  year_reg;
  reg  [15:0] ctrl_reg;
  reg  [14:0] shift_reg;
  reg  [15:0] calib_reg;
  reg  [16:0] wkReload_reg;
  reg  [16:0] wkCnt_reg;
  reg  [3:0]  wkDiv_reg;
  reg  [23:0] alarmT_reg;
  reg  [15:0] alarmD_reg;
  reg  [5:0]  status_reg;
  reg  [5:0]  mask_reg;
  reg  [6:0]  asyncCnt_reg;
  reg  [14:0] syncCnt_reg;
  reg  [19:0] calWin_reg;
  reg         insPend_reg;
  reg  [19:0] failCnt_reg;
  reg         xtalFail_reg;
  reg  [7:0]  tHist_reg [0:2];
  reg  [2:0]  tCondLast_reg;
  reg         secTickD_reg;
  reg  [7:0]  awAddr_reg;
  reg         awHeld_reg;
  reg  [31:0] wData_reg;
  reg  [3:0]  wStrb_reg;
  reg         wHeld_reg;

  // ****************
  // pin synchronisers and clock selection
  // ****************
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      xtalSync <= 2'h0;
      rcSync   <= 2'h0;
      tSync0   <= 2'h0;
      tSync1   <= 2'h0;
      tSync2   <= 2'h0;
      xtalLast <= 1'b0;
      rcLast   <= 1'b0;
    end
    else
    begin
      xtalSync <= {xtalSync[0], xtalClkPin};
      rcSync   <= {rcSync[0], rcClkPin};
      tSync0   <= {tSync0[0], tamperPin[0]};
      tSync1   <= {tSync1[0], tamperPin[1]};
      tSync2   <= {tSync2[0], tamperPin[2]};
      xtalLast <= xtalSync[1];
      rcLast   <= rcSync[1];
    end
  end

  wire [2:0] tamperIn = {tSync2[1], tSync1[1], tSync0[1]};
  wire xtalRise = xtalSync[1] & ~xtalLast;
  wire rcRise   = rcSync[1] & ~rcLast;
  wire useRc    = ctrl_reg[`CTRL_RCSEL] | (xtalFail_reg & ctrl_reg[`CTRL_AUTORC]); // [RULE11]
  wire rtcTick  = useRc ? rcRise : xtalRise;

  // one pulse dropped at a 2048 boundary for each unit of the minus field per 2^20 window
  wire calSkip  = rtcTick & (calWin_reg[10:0] == 11'h000) & (calWin_reg[19:11] < calib_reg[8:0]); // [RULE5]
  wire effTick  = (rtcTick & ~calSkip) | insPend_reg;                                            // [RULE5]
  wire advance  = effTick & (shift_reg == 15'h0000);                                            // [RULE4]
  wire ckApre   = advance & (asyncCnt_reg == 7'h00);
  wire secTick  = ckApre & (syncCnt_reg == 15'h0000);

  // ****************
  // bus handshake terms
  // ****************
  wire awTake   = s_axi_awvalid & s_axi_awready;
  wire wTake    = s_axi_wvalid & s_axi_wready;
  wire arTake   = s_axi_arvalid & s_axi_arready;
  wire doWrite  = awHeld_reg & wHeld_reg & ~s_axi_bvalid;
  wire [31:0] wv = wData_reg;
  wire wrTime   = doWrite & (awAddr_reg == `OFS_TIME);
  wire wrDate   = doWrite & (awAddr_reg == `OFS_DATE);
  wire rdStatus = arTake & (s_axi_araddr == `OFS_STATUS);

  // ****************
  // calendar advance
  // ****************
  reg [6:0] secN;
  reg [6:0] minN;
  reg [5:0] hourN;
  reg       pmN;
  reg [2:0] wdayN;
  reg [5:0] dateN;
  reg [4:0] monthN;
  reg [7:0] yearN;
  reg       dayCarry;
  reg [7:0] tmp;

  always @*
  begin
    secN = sec_reg; minN = min_reg; hourN = hour_reg; pmN = pm_reg;
    wdayN = wday_reg; dateN = date_reg; monthN = month_reg; yearN = year_reg;
    dayCarry = 1'b0;
    tmp = 8'h00;
    if (secTick)
    begin
      tmp = bcdInc({1'b0, sec_reg});
      secN = (sec_reg == 7'h59) ? 7'h00 : tmp[6:0];                         // [RULE1]
      if (sec_reg == 7'h59)
      begin
        tmp = bcdInc({1'b0, min_reg});
        minN = (min_reg == 7'h59) ? 7'h00 : tmp[6:0];                       // [RULE13]
        if (min_reg == 7'h59)
        begin
          tmp = bcdInc({2'b00, hour_reg});
          if (ctrl_reg[`CTRL_FMT12])
          begin
            if (hour_reg == 6'h11)
            begin
              hourN = 6'h12;
              pmN = ~pm_reg;
              dayCarry = pm_reg;                                            // [RULE1]
            end
            else
              hourN = (hour_reg == 6'h12) ? 6'h01 : tmp[5:0];
          end
          else
          begin
            hourN = (hour_reg == 6'h23) ? 6'h00 : tmp[5:0];
            dayCarry = (hour_reg == 6'h23);                                 // [RULE13]
          end
        end
      end
    end
    if (dayCarry)
    begin
      wdayN = (wday_reg == 3'h7) ? 3'h1 : wday_reg + 3'h1;
      tmp = bcdInc({2'b00, date_reg});
      dateN = (date_reg == lastDay(month_reg, year_reg)) ? 6'h01 : tmp[5:0]; // [RULE2]
      if (date_reg == lastDay(month_reg, year_reg))
      begin
        tmp = bcdInc({3'b000, month_reg});
        monthN = (month_reg == 5'h12) ? 5'h01 : tmp[4:0];                   // [RULE13]
        if (month_reg == 5'h12)
          yearN = (year_reg == 8'h99) ? 8'h00 : bcdInc(year_reg);
      end
    end
  end

  // ****************
  // alarm, wakeup and tamper events
  // ****************
  wire alarmHit = (alarmT_reg[7]  | (sec_reg == alarmT_reg[6:0])) &
                  (alarmT_reg[15] | (min_reg == alarmT_reg[14:8])) &
                  (alarmT_reg[23] | ({pm_reg, hour_reg} == alarmT_reg[22:16])) &
                  (alarmD_reg[7]  | (date_reg == alarmD_reg[5:0])) &
                  (alarmD_reg[15] | (month_reg == alarmD_reg[12:8]));       // [RULE9]

  reg wkTick;
  always @*
  begin
    case (ctrl_reg[`CTRL_WKSEL +: 3])
      3'h0:    wkTick = effTick & (wkDiv_reg == 4'hF);
      3'h1:    wkTick = effTick & (wkDiv_reg[2:0] == 3'h7);
      3'h2:    wkTick = effTick & (wkDiv_reg[1:0] == 2'h3);
      3'h3:    wkTick = effTick & wkDiv_reg[0];                             // [RULE7]
      default: wkTick = secTick;                                            // [RULE8]
    endcase
  end
  wire wkFire = ctrl_reg[`CTRL_WKEN] & wkTick & (wkCnt_reg == 17'h00000);   // [RULE6]

  reg [2:0] tCond;
  integer   i;
  integer   j;
  always @*
  begin
    tCond = 3'h0;
    for (i = 0; i < 3; i = i + 1)
    begin
      case (ctrl_reg[`CTRL_TFILT +: 2])
        2'h0:    tCond[i] = (tHist_reg[i][0] == ctrl_reg[`CTRL_TLEVEL]);
        2'h1:    tCond[i] = (tHist_reg[i][1:0] == {2{ctrl_reg[`CTRL_TLEVEL]}});
        2'h2:    tCond[i] = (tHist_reg[i][3:0] == {4{ctrl_reg[`CTRL_TLEVEL]}});
        default: tCond[i] = (tHist_reg[i] == {8{ctrl_reg[`CTRL_TLEVEL]}});
      endcase
      tCond[i] = tCond[i] & ctrl_reg[`CTRL_TAMPEN + i];
    end
  end

  wire failNow = (failCnt_reg == FAIL_CYCLES) & ~xtalRise;
  wire [5:0] evSet = {tCond & ~tCondLast_reg,                               // [RULE12]
                      failNow & ~xtalFail_reg,                               // [RULE10]
                      wkFire,
                      secTickD_reg & ctrl_reg[`CTRL_ALEN] & alarmHit};       // [RULE6]
  // a new event beats the read that clears it
  wire [5:0] statusNext = (status_reg & ~{6{rdStatus}}) | evSet;

  // ****************
  // timekeeping registers
  // ****************
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      sec_reg <= 7'h00; min_reg <= 7'h00; hour_reg <= 6'h00; pm_reg <= 1'b0;
      wday_reg <= 3'h1; date_reg <= 6'h01; month_reg <= 5'h01; year_reg <= 8'h00;
      asyncCnt_reg <= `PREDIV_A;
      syncCnt_reg  <= `PREDIV_S;
      shift_reg    <= 15'h0000;
      calWin_reg   <= 20'h00000;
      insPend_reg  <= 1'b0;
      secTickD_reg <= 1'b0;
      wkDiv_reg    <= 4'h0;
      wkCnt_reg    <= `WAKE_RESET;
      failCnt_reg  <= 20'h00000;
      xtalFail_reg <= 1'b0;
      tHist_reg[0] <= 8'h00;
      tHist_reg[1] <= 8'h00;
      tHist_reg[2] <= 8'h00;
      tCondLast_reg <= 3'h0;
      status_reg   <= 6'h00;
      irq          <= 1'b0;
    end
    else
    begin
      secTickD_reg <= secTick;
      if (wrTime)
      begin
        sec_reg  <= wv[6:0];
        min_reg  <= wv[14:8];
        hour_reg <= wv[21:16];
        pm_reg   <= wv[22];
      end
      else
      begin
        sec_reg <= secN; min_reg <= minN; hour_reg <= hourN; pm_reg <= pmN;
      end
      if (wrDate)
      begin
        date_reg  <= wv[5:0];
        month_reg <= wv[12:8];
        wday_reg  <= wv[15:13];
        year_reg  <= wv[23:16];
      end
      else
      begin
        wday_reg <= wdayN; date_reg <= dateN; month_reg <= monthN; year_reg <= yearN;
      end
      // a calendar write restarts the second
      if (wrTime | wrDate)
      begin
        asyncCnt_reg <= `PREDIV_A;
        syncCnt_reg  <= `PREDIV_S;
      end
      else if (advance)
      begin
        asyncCnt_reg <= (asyncCnt_reg == 7'h00) ? `PREDIV_A : asyncCnt_reg - 7'h01;
        if (ckApre)
          syncCnt_reg <= (syncCnt_reg == 15'h0000) ? `PREDIV_S : syncCnt_reg - 15'h0001; // [RULE3]
      end
      if (doWrite & (awAddr_reg == `OFS_SHIFT))
        shift_reg <= wv[14:0];
      else if (effTick & (shift_reg != 15'h0000))
        shift_reg <= shift_reg - 15'h0001;                                  // [RULE4]
      if (rtcTick)
        calWin_reg <= calWin_reg + 20'h00001;
      insPend_reg <= rtcTick & calib_reg[`CALIB_PLUS] & (calWin_reg[10:0] == 11'h400); // [RULE5]
      if (effTick)
        wkDiv_reg <= wkDiv_reg + 4'h1;
      if (!ctrl_reg[`CTRL_WKEN] | wkFire)
        wkCnt_reg <= wkReload_reg;
      else if (wkTick)
        wkCnt_reg <= wkCnt_reg - 17'h00001;
      if (xtalRise)
      begin
        failCnt_reg  <= 20'h00000;
        xtalFail_reg <= 1'b0;
      end
      else if (failNow)
        xtalFail_reg <= 1'b1;                                               // [RULE10]
      else
        failCnt_reg <= failCnt_reg + 20'h00001;
      if (rtcTick)
        for (j = 0; j < 3; j = j + 1)
          tHist_reg[j] <= {tHist_reg[j][6:0], tamperIn[j]}; // [RULE12]
      tCondLast_reg <= tCond;
      status_reg <= statusNext;
      irq <= |(statusNext & mask_reg);
    end
  end

  // ****************
  // bus slave and configuration registers
  // ****************
  wire wrHit = (awAddr_reg <= `OFS_MASK) & (awAddr_reg[1:0] == 2'h0);
  wire [31:0] ctrlMerged = merge({16'h0000, ctrl_reg}, wv, wStrb_reg);

  reg [31:0] rdMux;
  always @*
  begin
    case (s_axi_araddr)
      `OFS_TIME:   rdMux = {9'h000, pm_reg, hour_reg, 1'b0, min_reg, 1'b0, sec_reg};
      `OFS_DATE:   rdMux = {8'h00, year_reg, wday_reg, month_reg, 2'h0, date_reg};
      `OFS_SUBSEC: rdMux = {17'h00000, syncCnt_reg};                        // [RULE3]
      `OFS_CTRL:   rdMux = {16'h0000, ctrl_reg};
      `OFS_SHIFT:  rdMux = {17'h00000, shift_reg};
      `OFS_CALIB:  rdMux = {16'h0000, calib_reg};
      `OFS_WAKEUP: rdMux = {15'h0000, wkReload_reg};
      `OFS_ALARMT: rdMux = {8'h00, alarmT_reg};
      `OFS_ALARMD: rdMux = {16'h0000, alarmD_reg};
      `OFS_STATUS: rdMux = {23'h000000, useRc, 2'h0, status_reg};
      `OFS_MASK:   rdMux = {26'h0000000, mask_reg};
      default:     rdMux = 32'h00000000;
    endcase
  end

  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_awready <= 1'b0; s_axi_wready <= 1'b0; s_axi_bvalid <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      s_axi_arready <= 1'b0; s_axi_rvalid <= 1'b0;
      s_axi_rdata   <= 32'h00000000; s_axi_rresp <= `RESP_OKAY;
      awHeld_reg <= 1'b0; awAddr_reg <= 8'h00;
      wHeld_reg  <= 1'b0; wData_reg <= 32'h00000000; wStrb_reg <= 4'h0;
      ctrl_reg     <= `CTRL_RESET;
      calib_reg    <= 16'h0000;
      wkReload_reg <= `WAKE_RESET;
      alarmT_reg   <= 24'h000000;
      alarmD_reg   <= 16'h0000;
      mask_reg     <= 6'h00;
    end
    else
    begin
      if (awTake)
      begin
        awAddr_reg <= s_axi_awaddr;
        awHeld_reg <= 1'b1;
      end
      else if (doWrite)
        awHeld_reg <= 1'b0;
      if (wTake)
      begin
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
        wHeld_reg <= 1'b1;
      end
      else if (doWrite)
        wHeld_reg <= 1'b0;
      s_axi_awready <= ~(awHeld_reg | awTake) & ~(s_axi_bvalid & ~s_axi_bready);
      s_axi_wready  <= ~(wHeld_reg | wTake) & ~(s_axi_bvalid & ~s_axi_bready);
      s_axi_bvalid  <= (s_axi_bvalid & ~s_axi_bready) | doWrite;
      if (doWrite)
      begin
        s_axi_bresp <= wrHit ? `RESP_OKAY : `RESP_SLVERR;
        case (awAddr_reg)
          `OFS_CTRL:   ctrl_reg     <= ctrlMerged[15:0];
          `OFS_CALIB:  calib_reg    <= wv[15:0];
          `OFS_WAKEUP: wkReload_reg <= wv[16:0];
          `OFS_ALARMT: alarmT_reg   <= wv[23:0];
          `OFS_ALARMD: alarmD_reg   <= wv[15:0];
          `OFS_MASK:   mask_reg     <= wv[5:0];
          default:     mask_reg     <= mask_reg;
        endcase
      end
      s_axi_arready <= ~arTake & ~(s_axi_rvalid & ~s_axi_rready);
      s_axi_rvalid  <= (s_axi_rvalid & ~s_axi_rready) | arTake;
      if (arTake)
      begin
        s_axi_rdata <= rdMux;
        s_axi_rresp <= ((s_axi_araddr <= `OFS_MASK) & (s_axi_araddr[1:0] == 2'h0)) ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

endmodule // rtc_calendar

/* core/rtc_calendar_map.vh */
// register offsets, field positions, reset values and timing counts of the calendar clock
`ifndef RTC_CALENDAR_MAP_VH
`define RTC_CALENDAR_MAP_VH

// ****************
// register byte offsets
// ****************
`define OFS_TIME     8'h00
`define OFS_DATE     8'h04
`define OFS_SUBSEC   8'h08
`define OFS_CTRL     8'h0C
`define OFS_SHIFT    8'h10
`define OFS_CALIB    8'h14
`define OFS_WAKEUP   8'h18
`define OFS_ALARMT   8'h1C
`define OFS_ALARMD   8'h20
`define OFS_STATUS   8'h24
`define OFS_MASK     8'h28

// ****************
// control and calibration field positions
// ****************
`define CTRL_FMT12   0
`define CTRL_WKEN    1
`define CTRL_ALEN    2
`define CTRL_RCSEL   3
`define CTRL_WKSEL   4
`define CTRL_AUTORC  7
`define CTRL_TAMPEN  8
`define CTRL_TLEVEL  11
`define CTRL_TFILT   12
`define CALIB_PLUS   15

// ****************
// status bit positions
// ****************
`define ST_ALARM     0
`define ST_WAKE      1
`define ST_XFAIL     2
`define ST_TAMP      3
`define ST_WIDTH     6

// ****************
// reset values and dividers
// ****************
`define CTRL_RESET   16'h0000
`define WAKE_RESET   17'h0FFFF
`define PREDIV_A     7'h7F
`define PREDIV_S     15'h00FF
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2

// ****************
// timing
// ****************
`define CLK_PERIOD_NS  10
`define FAIL_TIME_NS   100000
`define FAIL_CYCLES    (`FAIL_TIME_NS / `CLK_PERIOD_NS)

`endif

/* bench/rtc_calendar_chk.sv */
// port assertions of the calendar clock
`timescale 1ns/1ps
`include "rtc_calendar_map.vh"
module rtc_calendar_chk (
  input logic        clk_sys,
  input logic        resetn,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic [7:0]  s_axi_araddr,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic        irq
);
  // ****************
  // address of the read under way
  // ****************
  reg  [7:0] rdAddr;
  wire       rdOk = s_axi_rvalid && s_axi_rresp == `RESP_OKAY;
  always @(posedge clk_sys or negedge resetn)
    if (!resetn)
      rdAddr <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready)
      rdAddr <= s_axi_araddr;

  // ****************
  // assertions
  // ****************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer missing");
  AST_READ_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  AST_WRITE_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  AST_UNMAPPED: assert property (s_axi_rvalid && (rdAddr[1:0] != 2'h0 || rdAddr > `OFS_MASK) |-> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read answered");
  AST_TIME_BCD: assert property (rdOk && rdAddr == `OFS_TIME |-> s_axi_rdata[6:4] <= 3'h5 && s_axi_rdata[3:0] <= 4'h9
    && s_axi_rdata[14:12] <= 3'h5 && s_axi_rdata[11:8] <= 4'h9 && s_axi_rdata[21:16] <= 6'h23)
    else $error("time not bcd");
  AST_DATE_RANGE: assert property (rdOk && rdAddr == `OFS_DATE |-> s_axi_rdata[5:0] != 6'h0 && s_axi_rdata[5:0] <= 6'h31
    && s_axi_rdata[12:8] != 5'h0 && s_axi_rdata[12:8] <= 5'h12 && s_axi_rdata[15:13] != 3'h0)
    else $error("date out of range");
  AST_SUBSEC_BIN: assert property (rdOk && rdAddr == `OFS_SUBSEC |-> s_axi_rdata[31:8] == 24'h0)
    else $error("subsecond too wide");
  AST_SHIFT_MAX: assert property (rdOk && rdAddr == `OFS_SHIFT |-> s_axi_rdata[31:15] == 17'h0)
    else $error("shift count too wide");
  COV_ALARM: cover property (rdOk && rdAddr == `OFS_STATUS && s_axi_rdata[`ST_ALARM]);
  COV_IRQ: cover property ($rose(irq));
  COV_SLVERR: cover property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR);
endmodule // rtc_calendar_chk

/* bench/rtc_calendar_tb.sv */
// self-checking bench of the calendar clock
`timescale 1ns/1ps
`include "rtc_calendar_map.vh"
module rtc_calendar_tb;
  reg         clk_sys = 1'b0, resetn = 1'b0, xtalClkPin = 1'b0, rcClkPin = 1'b0, xtalRun = 1'b1;
  reg  [2:0]  tamperPin = 3'h0;
  reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg  [31:0] s_axi_wdata = 32'h0;
  reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  reg  [74:0] rows [0:13];
  reg  [31:0] rd;
  reg  [1:0]  rs;
  integer     fails = 0, comparisons = 0, i;

  rtc_calendar #(.FAIL_CYCLES(20'd500)) i_rtc_calendar (.clk_sys(clk_sys), .resetn(resetn),
    .xtalClkPin(xtalClkPin), .rcClkPin(rcClkPin), .tamperPin(tamperPin), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));

  // ****************
  // clocks: crystal and rc fast so one second fits the run
  // ****************
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    xtalClkPin <= xtalRun ? ~xtalClkPin : xtalClkPin;
    rcClkPin <= ~rcClkPin;
  end

  // ****************
  // tasks
  // ****************
  task check(input [255:0] what, input [31:0] seen, input [31:0] exp);
  begin
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("unexpected %0s expected %h seen %h", what, exp, seen);
    end
  end
  endtask
  task results;
  begin
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  task step(inout integer left);
  begin
    @(posedge clk_sys);
    left = left - 1;
    if (left <= 0)
    begin
      fails = fails + 1;
      $display("unexpected timeout expected answer seen none");
      results;
    end
  end
  endtask
  task axiWrite(input [7:0] a, input [31:0] d, output [1:0] r);
    integer left;
    reg     awOpen;
    reg     wOpen;
  begin
    left = 1000;
    awOpen = 1'b1;
    wOpen = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (awOpen || wOpen)
    begin
      step(left);
      if (s_axi_awready === 1'b1)
        awOpen = 1'b0;
      if (s_axi_wready === 1'b1)
        wOpen = 1'b0;
      s_axi_awvalid <= awOpen;
      s_axi_wvalid <= wOpen;
    end
    do step(left); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
  end
  endtask
  task axiRead(input [7:0] a, output [31:0] d, output [1:0] r);
    integer left;
  begin
    left = 1000;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do step(left); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do step(left); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  end
  endtask
  task waitIrq(input integer bound);
  begin
    while (irq !== 1'b1)
      step(bound);
  end
  endtask

  // ****************
  // main sequence
  // ****************
  initial
  begin
    rows[0] = {1'b0, `OFS_TIME, 32'h0, 32'h0, `RESP_OKAY};
    rows[1] = {1'b0, `OFS_DATE, 32'h0, 32'h00002101, `RESP_OKAY};
    rows[2] = {1'b0, `OFS_CTRL, 32'h0, 16'h0000, `CTRL_RESET, `RESP_OKAY};
    rows[3] = {1'b0, `OFS_WAKEUP, 32'h0, 15'h0000, `WAKE_RESET, `RESP_OKAY};
    rows[4] = {1'b0, `OFS_SHIFT, 32'h0, 32'h0, `RESP_OKAY};
    rows[5] = {1'b0, `OFS_STATUS, 32'h0, 32'h0, `RESP_OKAY};
    rows[6] = {1'b0, 8'h2C, 32'h0, 32'h0, `RESP_SLVERR};
    rows[7] = {1'b0, 8'h02, 32'h0, 32'h0, `RESP_SLVERR};
    rows[8] = {1'b1, `OFS_CALIB, 32'h00008001, 32'h00008001, `RESP_OKAY};
    rows[9] = {1'b1, `OFS_WAKEUP, 32'h0001FFFF, 32'h0001FFFF, `RESP_OKAY};
    rows[10] = {1'b1, `OFS_ALARMT, 32'h00808080, 32'h00808080, `RESP_OKAY};
    rows[11] = {1'b1, `OFS_ALARMD, 32'h00008080, 32'h00008080, `RESP_OKAY};
    rows[12] = {1'b1, 8'h2C, 32'h00000001, 32'h0, `RESP_SLVERR};
    rows[13] = {1'b1, `OFS_CTRL, 32'h00000001, 32'h00000001, `RESP_OKAY};
    repeat (2) @(posedge clk_sys);
    check("awready in reset", s_axi_awready, 32'h0);
    resetn <= 1'b1;
    @(posedge clk_sys);
    for (i = 0; i < 14; i = i + 1)
    begin
      if (rows[i][74])
      begin
        axiWrite(rows[i][73:66], rows[i][65:34], rs);
        check("write response", rs, rows[i][1:0]);
      end
      axiRead(rows[i][73:66], rd, rs);
      check("read response", rs, rows[i][1:0]);
      check("read data", rd, rows[i][33:2]);
    end
    axiRead(`OFS_SUBSEC, rd, rs);
    check("subsecond", rd <= 32'h000000FF, 32'h1);
    $display("register table done");
    axiWrite(`OFS_WAKEUP, 32'h00000003, rs);
    axiWrite(`OFS_MASK, 32'h00000000, rs);
    axiWrite(`OFS_CTRL, 32'h00000032, rs);
    repeat (200) @(posedge clk_sys);
    check("masked irq", irq, 32'h0);
    axiWrite(`OFS_MASK, 32'h00000002, rs);
    waitIrq(100);
    axiRead(`OFS_STATUS, rd, rs);
    check("wakeup flag", rd[`ST_WAKE], 32'h1);
    axiWrite(`OFS_CTRL, 32'h00000000, rs);
    axiRead(`OFS_STATUS, rd, rs);
    axiRead(`OFS_STATUS, rd, rs);
    check("cleared status", rd[5:0], 32'h0);
    repeat (2) @(posedge clk_sys);
    check("cleared irq", irq, 32'h0);
    $display("wakeup done");
    axiWrite(`OFS_CTRL, 32'h00000004, rs);
    axiWrite(`OFS_DATE, 32'h00016228, rs);
    axiWrite(`OFS_TIME, 32'h00235959, rs);
    axiWrite(`OFS_MASK, 32'h00000001, rs);
    axiRead(`OFS_STATUS, rd, rs);
    waitIrq(70000);
    axiRead(`OFS_TIME, rd, rs);
    check("time after rollover", rd, 32'h0);
    axiRead(`OFS_DATE, rd, rs);
    check("date after rollover", rd, 32'h00018301);
    axiRead(`OFS_STATUS, rd, rs);
    check("alarm flag", rd[`ST_ALARM], 32'h1);
    $display("rollover done");
    axiWrite(`OFS_CTRL, 32'h00000080, rs);
    axiWrite(`OFS_MASK, 32'h00000004, rs);
    xtalRun <= 1'b0;
    waitIrq(2000);
    axiRead(`OFS_STATUS, rd, rs);
    check("crystal fail and rc", rd & 32'h00000104, 32'h00000104);
    xtalRun <= 1'b1;
    $display("crystal fail done");
    axiWrite(`OFS_CTRL, 32'h00003C00, rs);
    axiWrite(`OFS_MASK, 32'h00000020, rs);
    axiRead(`OFS_STATUS, rd, rs);
    tamperPin <= 3'h4;
    @(posedge clk_sys);
    tamperPin <= 3'h0;
    repeat (50) @(posedge clk_sys);
    check("tamper glitch", irq, 32'h0);
    tamperPin <= 3'h4;
    waitIrq(200);
    axiRead(`OFS_STATUS, rd, rs);
    check("tamper flag", rd[5:3], 32'h4);
    $display("tamper done");
    axiWrite(`OFS_SHIFT, 32'h00007FFF, rs);
    axiRead(`OFS_SHIFT, rd, rs);
    check("shift left", rd <= 32'h00007FFF && rd >= 32'h00007FF0, 32'h1);
    $display("shift done");
    results;
  end
endmodule // rtc_calendar_tb

bind rtc_calendar rtc_calendar_chk i_rtc_calendar_chk (.clk_sys(clk_sys), .resetn(resetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .irq(irq));
